// ===== include/cfm_pkg.sv
/*
  Constants, register map and types of the configuration-and-fault supervisor.
  Assumes a single 200 MHz core clock and a 16-bit register port.
*/
package cfm_pkg;
  // Register port widths
  localparam int AW = 8;
  localparam int DW = 16;
  // Register offsets
  localparam logic [7:0] REG_GCFG = 8'h00;
  localparam logic [7:0] REG_ST_ADDR = 8'h01;
  localparam logic [7:0] REG_ST_VOUT0 = 8'h02;
  localparam logic [7:0] REG_ST_VOUT1 = 8'h03;
  localparam logic [7:0] REG_ST_FREQ = 8'h04;
  localparam logic [7:0] REG_ST_PHASE = 8'h05;
  localparam logic [7:0] REG_ADDR = 8'h06;
  localparam logic [7:0] REG_VOUT0 = 8'h07;
  localparam logic [7:0] REG_VOUT1 = 8'h08;
  localparam logic [7:0] REG_FREQ = 8'h09;
  localparam logic [7:0] REG_PHASE = 8'h0a;
  localparam logic [7:0] REG_OVLIM0 = 8'h0b;
  localparam logic [7:0] REG_OVLIM1 = 8'h0c;
  localparam logic [7:0] REG_UVLIM0 = 8'h0d;
  localparam logic [7:0] REG_UVLIM1 = 8'h0e;
  localparam logic [7:0] REG_STATUS = 8'h0f;
  localparam logic [7:0] REG_AMASK = 8'h10;
  localparam logic [7:0] REG_PROP0 = 8'h11;
  localparam logic [7:0] REG_PROP1 = 8'h12;
  localparam logic [7:0] REG_PINRESP = 8'h13;
  localparam logic [7:0] REG_RETRY = 8'h14;
  localparam logic [7:0] REG_CMD = 8'h15;
  localparam logic [7:0] REG_OPER = 8'h16;
  localparam logic [7:0] REG_PAD = 8'h17;
  // Global config fields
  localparam int GCFG_CLR_ALL = 0;
  localparam int GCFG_SYNC_DIS = 4;
  localparam int GCFG_PIN_DIS = 6;
  // Command fields (write-only pulses)
  localparam int CMD_CLR = 0;
  localparam int CMD_MRST = 1;
  localparam int CMD_RESTORE = 2;
  localparam int CMD_ARA = 3;
  // Status bit positions
  localparam int ST_OV0 = 0;
  localparam int ST_UV0 = 1;
  localparam int ST_OV1 = 2;
  localparam int ST_UV1 = 3;
  localparam int ST_EXT0 = 4;
  localparam int ST_EXT1 = 5;
  localparam int ST_CML = 6;
  localparam int ST_PLL = 7;
  localparam logic [7:0] CH0_MASK = 8'h13;
  localparam logic [7:0] CH1_MASK = 8'h2c;
  // Per-channel pin response nibble: pg mode, respond, retry
  localparam int PR_PG = 0;
  localparam int PR_RESP = 1;
  localparam int PR_RETRY = 2;
  localparam int PR_STRIDE = 4;
  localparam int PAD_SYNC_BIT = 10;
  // Reset values
  localparam logic [15:0] GCFG_RST = 16'h0000;
  localparam logic [6:0] ADDR_RST = 7'h40;
  localparam logic [15:0] VOUT_RST = 16'h0000;
  localparam logic [3:0] FREQ_RST = 4'h0;
  localparam logic [3:0] PHASE_RST = 4'h0;
  localparam logic [15:0] RETRY_RST = 16'h0096;
  // Strap code to millivolts
  localparam logic [15:0] VOUT_BASE = 16'h01f4;
  localparam logic [15:0] VOUT_STEP = 16'h00fa;
  // Timing: retry unit is one millisecond
  localparam longint CLK_HZ = 200000000;
  localparam longint RETRY_UNIT_US = 1000;
  localparam int MS_CYCLES = int'(RETRY_UNIT_US * CLK_HZ / 1000000);
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  // Channel recovery states
  typedef enum logic [3:0] {
    CH_OFF = 4'b0001,
    CH_ON = 4'b0010,
    CH_WAIT = 4'b0100,
    CH_LATCH = 4'b1000
  } cfm_ch_state_t;
endpackage

// ===== include/cfm_strap_if.sv
/*
  Carrier between the supervisor and its strap resolver.
  Assumes strap levels are already filtered in the core clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
interface cfm_strap_if;
  logic [3:0] addr_low_strap;
  logic [2:0] addr_high_strap;
  logic [3:0] frequency_strap;
  logic [3:0] phase_strap;
  logic [3:0] vout_strap [2];
  logic [5:0] strap_open;
  logic pin_dis;
  logic [6:0] st_addr;
  logic [15:0] st_vout [2];
  logic [3:0] st_freq;
  logic [3:0] st_phase;
  logic [6:0] addr;
  logic [15:0] vout [2];
  logic [3:0] freq;
  logic [3:0] phase;
  logic [1:0] vout_from_strap;
  modport resolver (
    input addr_low_strap, addr_high_strap, frequency_strap, phase_strap,
    input vout_strap, strap_open, pin_dis, st_addr, st_vout, st_freq,
    input st_phase,
    output addr, vout, freq, phase, vout_from_strap
  );
  modport user (
    output addr_low_strap, addr_high_strap, frequency_strap, phase_strap,
    output vout_strap, strap_open, pin_dis, st_addr, st_vout, st_freq,
    output st_phase,
    input addr, vout, freq, phase, vout_from_strap
  );
endinterface
`default_nettype wire

// ===== hdl/cfm_strap_resolve.sv
/*
  Strap resolver: picks strap-derived or stored values per parameter.
  Assumes open flags: 0 addr low, 1 addr high, 2 freq, 3 vout0, 4 vout1,
  5 phase. Purely combinational; the caller decides when to sample.
*/
`timescale 1ns/10ps
`default_nettype none
module cfm_strap_resolve
  import cfm_pkg::*;
(
  cfm_strap_if.resolver sif
);
  // Address straps are honoured even with straps disabled
  wire use_lo = !sif.strap_open[0];
  wire use_hi = !sif.strap_open[1];
  // Other straps obey the global pin-disable bit
  wire use_freq = !sif.strap_open[2] && !sif.pin_dis;
  wire use_v0 = !sif.strap_open[3] && !sif.pin_dis;
  wire use_v1 = !sif.strap_open[4] && !sif.pin_dis;
  wire use_ph = !sif.strap_open[5] && !sif.pin_dis;

  // Top three address bits, then bottom four, one driver for the word
  assign sif.addr = {use_hi ? sif.addr_high_strap : sif.st_addr[6:4],
    use_lo ? sif.addr_low_strap : sif.st_addr[3:0]};
  // Frequency and phase codes fall back to stored values
  assign sif.freq = use_freq ? sif.frequency_strap : sif.st_freq;
  assign sif.phase = use_ph ? sif.phase_strap : sif.st_phase;
  assign sif.vout_from_strap = {use_v1, use_v0};

  // Voltage code maps linearly from a base in millivolt steps
  genvar g;
  for (g = 0; g < 2; g++) begin : g_vout
    wire [15:0] code_mv = 16'(VOUT_BASE + VOUT_STEP * {12'h000, sif.vout_strap[g]});
    assign sif.vout[g] = sif.vout_from_strap[g] ? code_mv : sif.st_vout[g];
  end
endmodule
`default_nettype wire

// ===== hdl/cfm_top.sv
/*
  Configuration-and-fault supervisor for a dual-channel power controller:
  strap sampling, limits, sticky status, alert, fault pins and recovery.
  Assumes pins are asynchronous, the register master is on core_clk_i and
  fault pins are open drain, pulled high outside the device.
*/
// Decided for this implementation: the plain strobed port and the register offsets.
// Operation
// - Open straps use stored configuration values
// - Pin-disable bit ignores all but address straps
// - Straps sampled only at reset, reset, restore
// - Open voltage strap uses stored setpoint
// - Strapped voltage sets limits, overvoltage plus ten
// - Internal sync without output sets pad flag
// - No frequency, no sync raises lock fault
// - High address strap gives top three bits
// - Low address strap gives bottom four bits
// - Bus may override all but address straps
// - Propagate map pulls fault pin low
// - External low on fault pin is fault
// - Power-good pin shows window, released after reset
// - Every unmasked event sets status and alert
// - Alert held until one clearing action occurs
// - Off-on clears channel faults, or all
// - Retry mode restarts after interval when clear
// - Channel shuts down when bussed pin low
// - Group retry releases pin; latch holds it
`timescale 1ns/10ps
`default_nettype none
module cfm_top
  import cfm_pkg::*;
#(
  parameter int MS_TICKS = MS_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [AW-1:0] reg_addr_i,
  input wire logic [DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DW-1:0] reg_rdata_o,
  input wire logic [3:0] addr_low_strap_i,
  input wire logic [2:0] addr_high_strap_i,
  input wire logic [3:0] frequency_strap_i,
  input wire logic [3:0] phase_strap_i,
  input wire logic [3:0] output_voltage_strap0_i,
  input wire logic [3:0] output_voltage_strap1_i,
  input wire logic [5:0] strap_open_i,
  input wire logic [1:0] run_pin_i,
  input wire logic ext_sync_present_i,
  input wire logic [1:0] vout_ov_i,
  input wire logic [1:0] vout_uv_i,
  input wire logic comm_memory_logic_fault_i,
  input wire logic [1:0] fault_pin_i,
  output logic [1:0] fault_pin_o,
  output logic [1:0] fault_pin_oe_o,
  output logic alert_n_o,
  output logic [1:0] chan_en_o,
  output logic [1:0] soft_start_o,
  output logic [6:0] slave_addr_o,
  output logic [15:0] vout0_o,
  output logic [15:0] vout1_o
);
  localparam int PW = 34; // Width of the synchronised pin bundle

  // Pin synchroniser: three stages, change taken when stages 2 and 3 agree
  wire [PW-1:0] pin_raw = {ext_sync_present_i, fault_pin_i, run_pin_i, strap_open_i,
    output_voltage_strap1_i, output_voltage_strap0_i, phase_strap_i,
    frequency_strap_i, addr_high_strap_i, addr_low_strap_i};
  logic [PW-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q;
  genvar b;
  for (b = 0; b < PW; b++) begin : g_sync
    always_ff @(posedge core_clk_i) begin
      pin_s1_q[b] <= pin_raw[b];
      pin_s2_q[b] <= pin_s1_q[b];
      pin_s3_q[b] <= pin_s2_q[b];
      // Filtered level only moves once two stages agree
      if (rst_i) begin
        pin_f_q[b] <= 1'b1;
      end else if (pin_s2_q[b] == pin_s3_q[b]) begin
        pin_f_q[b] <= pin_s3_q[b];
      end
    end
  end
  wire [1:0] run_s = pin_f_q[30:29];
  wire [1:0] fpin_s = pin_f_q[32:31];
  wire sync_ext_s = pin_f_q[33];

  // Configuration registers, stored set and effective set
  logic [15:0] gcfg_q; // Global config
  logic [6:0] st_addr_q; // Stored slave address
  logic [15:0] st_vout_q [2]; // Stored output voltage setpoints
  logic [3:0] st_freq_q, st_phase_q; // Stored frequency and phase codes
  logic [6:0] addr_q; // Effective address, read only
  logic [15:0] vout_q [2]; // Effective setpoints
  logic [3:0] freq_q, phase_q; // Effective frequency and phase
  logic [15:0] ovlim_q [2], uvlim_q [2]; // Fault limits
  logic [7:0] status_q, amask_q; // Sticky status and alert mask
  logic [7:0] prop_q [2]; // Propagate maps per fault pin
  logic [7:0] presp_q; // Pin response nibbles
  logic [15:0] retry_q; // Retry interval in milliseconds
  logic [1:0] oper_q; // Bus on/off per channel
  logic alarm_q; // Alert latch
  logic load_pend_q; // Strap sample pending
  logic [1:0] settle_q; // Wait for synchroniser to fill
  logic load_done_q; // Straps taken at least once
  logic [DW-1:0] rdata_q;
  logic [1:0] pin_oe_q;

  // Strap resolver
  cfm_strap_if sif ();
  assign sif.addr_low_strap = pin_f_q[3:0];
  assign sif.addr_high_strap = pin_f_q[6:4];
  assign sif.frequency_strap = pin_f_q[10:7];
  assign sif.phase_strap = pin_f_q[14:11];
  assign sif.vout_strap[0] = pin_f_q[18:15];
  assign sif.vout_strap[1] = pin_f_q[22:19];
  assign sif.strap_open = pin_f_q[28:23];
  assign sif.pin_dis = gcfg_q[GCFG_PIN_DIS];
  assign sif.st_addr = st_addr_q;
  assign sif.st_vout = st_vout_q;
  assign sif.st_freq = st_freq_q;
  assign sif.st_phase = st_phase_q;
  cfm_strap_resolve u_resolve (
    .sif(sif)
  );

  // Write decode
  wire wr_gcfg = reg_wr_i && (reg_addr_i == REG_GCFG);
  wire wr_cmd = reg_wr_i && (reg_addr_i == REG_CMD);
  wire wr_stat = reg_wr_i && (reg_addr_i == REG_STATUS);
  wire cmd_clr = wr_cmd && reg_wdata_i[CMD_CLR];
  wire cmd_mrst = wr_cmd && reg_wdata_i[CMD_MRST];
  wire cmd_rest = wr_cmd && reg_wdata_i[CMD_RESTORE];
  wire cmd_ara = wr_cmd && reg_wdata_i[CMD_ARA];
  // Straps may only be taken on these occasions
  wire load_req = cmd_mrst || cmd_rest;
  wire load_now = load_pend_q && (settle_q == STRAP_SETTLE);
  // Clearing actions shared by status and alert
  wire clr_all = cmd_clr || cmd_mrst || cmd_rest;

  // Strap sample sequencing: wait for filtered levels after reset
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      load_pend_q <= 1'b1;
      settle_q <= 2'h0;
      load_done_q <= 1'b0;
    end else if (load_now) begin
      load_pend_q <= 1'b0;
      load_done_q <= 1'b1;
    end else if (load_req) begin
      load_pend_q <= 1'b1;
      settle_q <= 2'h0;
    end else if (load_pend_q) begin
      settle_q <= 2'(settle_q + 2'h1);
    end
  end

  // Stored configuration and simple writable registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      gcfg_q <= GCFG_RST;
      st_addr_q <= ADDR_RST;
      st_freq_q <= FREQ_RST;
      st_phase_q <= PHASE_RST;
      amask_q <= 8'h00;
      presp_q <= 8'h00;
      retry_q <= RETRY_RST;
      oper_q <= 2'h3;
    end else if (reg_wr_i) begin
      if (wr_gcfg) begin
        gcfg_q <= reg_wdata_i;
      end else if (reg_addr_i == REG_ST_ADDR) begin
        st_addr_q <= reg_wdata_i[6:0];
      end else if (reg_addr_i == REG_ST_FREQ) begin
        st_freq_q <= reg_wdata_i[3:0];
      end else if (reg_addr_i == REG_ST_PHASE) begin
        st_phase_q <= reg_wdata_i[3:0];
      end else if (reg_addr_i == REG_AMASK) begin
        amask_q <= reg_wdata_i[7:0];
      end else if (reg_addr_i == REG_PINRESP) begin
        presp_q <= reg_wdata_i[7:0];
      end else if (reg_addr_i == REG_RETRY) begin
        // Host keeps this inside its legal range; no clamp here
        retry_q <= reg_wdata_i;
      end else if (reg_addr_i == REG_OPER) begin
        oper_q <= reg_wdata_i[1:0];
      end
    end
  end

  // Frequency, phase and address: strap sample first, bus override of frequency and phase after
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      addr_q <= ADDR_RST;
      freq_q <= FREQ_RST;
      phase_q <= PHASE_RST;
    end else if (load_now) begin
      addr_q <= sif.addr;
      freq_q <= sif.freq;
      phase_q <= sif.phase;
    end else if (reg_wr_i && reg_addr_i == REG_FREQ) begin
      freq_q <= reg_wdata_i[3:0];
    end else if (reg_wr_i && reg_addr_i == REG_PHASE) begin
      phase_q <= reg_wdata_i[3:0];
    end
  end

  // Per-channel voltage, limits and propagate map
  genvar c;
  for (c = 0; c < 2; c++) begin : g_cfg
    wire [7:0] o_stv = (c == 0) ? REG_ST_VOUT0 : REG_ST_VOUT1;
    wire [7:0] o_v = (c == 0) ? REG_VOUT0 : REG_VOUT1;
    wire [7:0] o_ov = (c == 0) ? REG_OVLIM0 : REG_OVLIM1;
    wire [7:0] o_uv = (c == 0) ? REG_UVLIM0 : REG_UVLIM1;
    wire [7:0] o_pr = (c == 0) ? REG_PROP0 : REG_PROP1;
    wire [15:0] tenth = sif.vout[c] / 16'h000a;
    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        st_vout_q[c] <= VOUT_RST;
        vout_q[c] <= VOUT_RST;
        ovlim_q[c] <= 16'h0000;
        uvlim_q[c] <= 16'h0000;
        prop_q[c] <= 8'h00;
      end else if (load_now) begin
        vout_q[c] <= sif.vout[c];
        // Limits follow a strapped voltage, else keep stored ones
        if (sif.vout_from_strap[c]) begin
          ovlim_q[c] <= 16'(sif.vout[c] + tenth);
          uvlim_q[c] <= 16'(sif.vout[c] - tenth);
        end
      end else if (reg_wr_i) begin
        if (reg_addr_i == o_stv) begin
          st_vout_q[c] <= reg_wdata_i;
        end else if (reg_addr_i == o_v) begin
          vout_q[c] <= reg_wdata_i;
        end else if (reg_addr_i == o_ov) begin
          ovlim_q[c] <= reg_wdata_i;
        end else if (reg_addr_i == o_uv) begin
          uvlim_q[c] <= reg_wdata_i;
        end else if (reg_addr_i == o_pr) begin
          prop_q[c] <= reg_wdata_i[7:0];
        end
      end
    end
  end

  // Our own pull echoes through the four-flop pin path after release
  logic [7:0] oe_hist_q;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      oe_hist_q <= 8'h00;
    end else begin
      oe_hist_q <= {oe_hist_q[5:0], pin_oe_q};
    end
  end
  wire [1:0] oe_recent = oe_hist_q[7:6] | oe_hist_q[5:4] | oe_hist_q[3:2] | oe_hist_q[1:0];
  // External fault: pin low while we are not, nor were lately, pulling it
  wire [1:0] ext_low = ~fpin_s & ~pin_oe_q & ~oe_recent;
  // Lock fault: no frequency code and no external sync
  wire pll_ev = load_done_q && (freq_q == 4'h0) && !sync_ext_s;
  wire [7:0] ev = {pll_ev, comm_memory_logic_fault_i, ext_low,
    vout_uv_i[1], vout_ov_i[1], vout_uv_i[0], vout_ov_i[0]};
  // Off-to-on edges of each channel, from run pin and bus command
  wire [1:0] on_req = run_s & oper_q;
  logic [1:0] on_prev_q;
  wire [1:0] on_edge = on_req & ~on_prev_q;
  wire clr_opt = gcfg_q[GCFG_CLR_ALL];
  wire [7:0] ch_clr = (on_edge[0] ? CH0_MASK : 8'h00) | (on_edge[1] ? CH1_MASK : 8'h00);
  wire [7:0] tog_clr = (clr_opt && |on_edge) ? 8'hff : ch_clr;
  wire [7:0] w1c = wr_stat ? reg_wdata_i[7:0] : 8'h00;
  wire [7:0] st_clr = (clr_all ? 8'hff : 8'h00) | w1c | tog_clr;
  // Set wins over any clear in the same cycle
  wire [7:0] status_d = (status_q & ~st_clr) | ev;
  wire alarm_set = |(ev & ~amask_q);
  wire alarm_clr = clr_all || cmd_ara || (|w1c);
  wire alarm_d = alarm_set || (alarm_q && !alarm_clr);

  // Status and alert latch
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      status_q <= 8'h00;
      alarm_q <= 1'b0;
      on_prev_q <= 2'h0;
    end else begin
      status_q <= status_d;
      alarm_q <= alarm_d;
      on_prev_q <= on_req;
    end
  end

  // Shared millisecond tick for the retry timers
  logic [$clog2(MS_TICKS)-1:0] ms_cnt_q;
  wire ms_tick = (ms_cnt_q == ($clog2(MS_TICKS))'(MS_TICKS - 1));
  always_ff @(posedge core_clk_i) begin
    if (rst_i || ms_tick) begin
      ms_cnt_q <= '0;
    end else begin
      ms_cnt_q <= ms_cnt_q + 1'b1;
    end
  end

  // Channel recovery machines and fault pin drive
  logic [1:0] en_q, ss_q;
  for (c = 0; c < 2; c++) begin : g_ch
    cfm_ch_state_t st_q;
    logic [15:0] rcnt_q;
    wire [3:0] pr = presp_q[c*PR_STRIDE +: 4];
    wire live = vout_ov_i[c] | vout_uv_i[c];
    // Trip sources: output window and a bussed pin held low elsewhere
    wire trip = live | (ext_low[c] & pr[PR_RESP]);
    wire ri_done = ms_tick && (rcnt_q >= 16'(retry_q - 16'h0001));
    wire [7:0] prmap = prop_q[c];
    wire mapped = |(ev & prmap & ~(8'h10 << c));
    wire held = (st_q == CH_WAIT) || (st_q == CH_LATCH);
    // Power-good mode: released until straps taken, then low outside window
    wire pg_low = load_done_q && live;
    wire oe_d = pr[PR_PG] ? pg_low : (mapped || held);
    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        st_q <= CH_OFF;
        rcnt_q <= 16'h0000;
        en_q[c] <= 1'b0;
        ss_q[c] <= 1'b0;
        pin_oe_q[c] <= 1'b0;
      end else begin
        ss_q[c] <= 1'b0;
        pin_oe_q[c] <= oe_d;
        case (st_q)
          CH_OFF: begin
            // Start only once straps have set the setpoint
            if (on_req[c] && load_done_q) begin
              st_q <= CH_ON;
              en_q[c] <= 1'b1;
              ss_q[c] <= 1'b1;
            end
          end
          CH_ON: begin
            if (!on_req[c]) begin
              st_q <= CH_OFF;
              en_q[c] <= 1'b0;
            end else if (trip) begin
              st_q <= pr[PR_RETRY] ? CH_WAIT : CH_LATCH;
              en_q[c] <= 1'b0;
              rcnt_q <= 16'h0000;
            end
          end
          CH_WAIT: begin
            if (!on_req[c]) begin
              st_q <= CH_OFF;
            end else if (ri_done && !trip) begin
              st_q <= CH_ON;
              en_q[c] <= 1'b1;
              ss_q[c] <= 1'b1;
            end else if (ri_done) begin
              rcnt_q <= 16'h0000;
            end else if (ms_tick) begin
              rcnt_q <= rcnt_q + 16'h0001;
            end
          end
          CH_LATCH: begin
            // Only an off command or run pin low releases a latch
            if (!on_req[c]) begin
              st_q <= CH_OFF;
            end
          end
          default: begin
            st_q <= CH_OFF;
            en_q[c] <= 1'b0;
          end
        endcase
      end
    end
  end

  // Pad status: internal sync with output not selected
  wire [15:0] pad = 16'(!sync_ext_s && gcfg_q[GCFG_SYNC_DIS]) << PAD_SYNC_BIT;

  // Read mux, unmapped and write-only offsets read zero
  wire [DW-1:0] rd_mux =
    (reg_addr_i == REG_GCFG) ? gcfg_q :
    (reg_addr_i == REG_ST_ADDR) ? {9'h000, st_addr_q} :
    (reg_addr_i == REG_ST_VOUT0) ? st_vout_q[0] :
    (reg_addr_i == REG_ST_VOUT1) ? st_vout_q[1] :
    (reg_addr_i == REG_ST_FREQ) ? {12'h000, st_freq_q} :
    (reg_addr_i == REG_ST_PHASE) ? {12'h000, st_phase_q} :
    (reg_addr_i == REG_ADDR) ? {9'h000, addr_q} :
    (reg_addr_i == REG_VOUT0) ? vout_q[0] :
    (reg_addr_i == REG_VOUT1) ? vout_q[1] :
    (reg_addr_i == REG_FREQ) ? {12'h000, freq_q} :
    (reg_addr_i == REG_PHASE) ? {12'h000, phase_q} :
    (reg_addr_i == REG_OVLIM0) ? ovlim_q[0] :
    (reg_addr_i == REG_OVLIM1) ? ovlim_q[1] :
    (reg_addr_i == REG_UVLIM0) ? uvlim_q[0] :
    (reg_addr_i == REG_UVLIM1) ? uvlim_q[1] :
    (reg_addr_i == REG_STATUS) ? {8'h00, status_q} :
    (reg_addr_i == REG_AMASK) ? {8'h00, amask_q} :
    (reg_addr_i == REG_PROP0) ? {8'h00, prop_q[0]} :
    (reg_addr_i == REG_PROP1) ? {8'h00, prop_q[1]} :
    (reg_addr_i == REG_PINRESP) ? {8'h00, presp_q} :
    (reg_addr_i == REG_RETRY) ? retry_q :
    (reg_addr_i == REG_OPER) ? {14'h0000, oper_q} :
    (reg_addr_i == REG_PAD) ? pad : 16'h0000;

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= reg_rd_i ? rd_mux : 16'h0000;
    end
  end

  // Open-drain pins only ever pull low
  assign fault_pin_o = 2'h0;
  assign fault_pin_oe_o = pin_oe_q;
  assign reg_rdata_o = rdata_q;
  assign alert_n_o = !alarm_q;
  assign chan_en_o = en_q;
  assign soft_start_o = ss_q;
  assign slave_addr_o = addr_q;
  assign vout0_o = vout_q[0];
  assign vout1_o = vout_q[1];
endmodule
`default_nettype wire

// ===== dv/cfm_top_assertions.sv
/* Port checker for cfm_top, bound to every instance.
   Assumes the single core clock and its synchronous reset. */
`timescale 1ns/10ps
`default_nettype none
module cfm_top_assertions (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic reg_wr_i,
  input wire logic [3:0] addr_low_strap_i,
  input wire logic [1:0] vout_ov_i,
  input wire logic [1:0] run_pin_i,
  input wire logic alert_n_o,
  input wire logic [1:0] fault_pin_oe_o,
  input wire logic [1:0] chan_en_o,
  input wire logic [1:0] soft_start_o,
  input wire logic [6:0] slave_addr_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Reset must leave alert idle and both pins floating
  a_alert_idle: assert property (disable iff (1'b0) rst_i |=> alert_n_o)
    else $error("alert low after reset");
  a_pin_float: assert property (disable iff (1'b0) rst_i |=> !fault_pin_oe_o)
    else $error("pin driven after reset");
  a_ov_alert: assert property ($rose(vout_ov_i[0]) |-> ##[1:3] !alert_n_o)
    else $error("no alert on overvoltage");
  // Only a register write may release a pending alert
  a_alert_held: assert property (!alert_n_o && !$past(reg_wr_i) && !reg_wr_i |=> !alert_n_o)
    else $error("alert released by itself");
  a_addr_pinned: assert property ($changed(addr_low_strap_i) |=> $stable(slave_addr_o) [*8])
    else $error("address followed a strap");
  a_start_pulse: assert property ($rose(chan_en_o[0]) |-> soft_start_o[0])
    else $error("start without soft start");
  a_ov_trip: assert property (vout_ov_i[0] && chan_en_o[0] |-> ##[1:2] !chan_en_o[0])
    else $error("channel kept running");
  a_retry_gap: assert property ($fell(chan_en_o[0]) && run_pin_i[0] |=> !chan_en_o[0] [*8])
    else $error("restart too early");
endmodule
bind cfm_top cfm_top_assertions u_cfm_top_assertions (.core_clk_i, .rst_i, .reg_wr_i,
  .addr_low_strap_i, .vout_ov_i, .run_pin_i, .alert_n_o, .fault_pin_oe_o, .chan_en_o,
  .soft_start_o, .slave_addr_o);
`default_nettype wire

// ===== dv/cfm_far_side.sv
/* Far side of the two open-drain fault pins: pull-ups and a neighbour.
   Assumes released pins idle high. */
`timescale 1ns/10ps
`default_nettype none
module cfm_far_side (
  input wire logic [1:0] oe_i,
  input wire logic [1:0] pull_i,
  output logic [1:0] pin_o
);
  // Wired-and over the pull-up; a neighbour pulling low looks like a fault
  assign pin_o = ~(oe_i | pull_i);
endmodule
`default_nettype wire

// ===== dv/test_config_pin_and_fault_manager.sv
/* Bench for cfm_top: strap sampling, latch, retry and external faults.
   Assumes an 8-cycle millisecond tick and the far-side pin model. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin fails++; \
  $display("unexpected %s expected %h seen %h", nm, e, s); end end
module test_config_pin_and_fault_manager
  import cfm_pkg::*;
;
  localparam logic [15:0] V1 = VOUT_BASE + 16'h0004 * VOUT_STEP; // Strap code 4
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic ext_sync_present_i = 1'b0;
  logic comm_memory_logic_fault_i = 1'b0;
  logic alert_n_o;
  logic [7:0] reg_addr_i = 8'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic [15:0] reg_rdata_o, vout0_o, vout1_o;
  logic [3:0] addr_low_strap_i = 4'h5, frequency_strap_i = 4'h1, phase_strap_i = 4'h2;
  logic [3:0] output_voltage_strap0_i = 4'h0, output_voltage_strap1_i = 4'h4;
  logic [2:0] addr_high_strap_i = 3'h2;
  logic [5:0] strap_open_i = 6'h08;
  logic [1:0] run_pin_i = 2'h3, vout_ov_i = 2'h0, vout_uv_i = 2'h0, pull = 2'h0;
  logic [1:0] fault_pin_i, fault_pin_oe_o, chan_en_o, soft_start_o;
  logic [6:0] slave_addr_o;
  int fails = 0, n_compared = 0, k;
  cfm_top #(.MS_TICKS(8)) u_cfm_top (.*, .fault_pin_o());
  cfm_far_side u_cfm_far_side (.oe_i(fault_pin_oe_o), .pull_i(pull), .pin_o(fault_pin_i));
  initial forever #2.5 core_clk_i = ~core_clk_i;
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 `CHK("read data", e, reg_rdata_o)
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    tick(10);
    rst_i <= 1'b0;
    wr_reg(REG_PINRESP, 16'h0000);
    wr_reg(REG_PROP1, 16'h0000);
    tick(6);
    `CHK("address", 7'h25, slave_addr_o)
    `CHK("vout0", VOUT_RST, vout0_o)
    `CHK("vout1", V1, vout1_o)
    rd_chk(REG_OVLIM1, V1 + V1 / 16'h000a);
    rd_chk(8'h3f, 16'h0000);
    wr_reg(REG_VOUT1, 16'h0321);
    tick(2);
    `CHK("vout1", 16'h0321, vout1_o)
    // Latched overvoltage, then run toggle and clear command
    vout_ov_i[0] <= 1'b1;
    tick(2);
    vout_ov_i[0] <= 1'b0;
    tick(3);
    `CHK("latched", 4'h6, {fault_pin_oe_o, chan_en_o})
    rd_chk(REG_STATUS, 16'h0001);
    run_pin_i[0] <= 1'b0;
    tick(12);
    run_pin_i[0] <= 1'b1;
    tick(12);
    `CHK("restarted", 4'h3, {fault_pin_oe_o, chan_en_o})
    rd_chk(REG_STATUS, 16'h0000);
    `CHK("alert", 1'b0, alert_n_o)
    wr_reg(REG_CMD, 16'h0001 << CMD_CLR);
    tick(2);
    `CHK("alert", 1'b1, alert_n_o)
    // Retry mode with an interval just above the legal minimum
    wr_reg(REG_RETRY, 16'h0079);
    wr_reg(REG_PINRESP, 16'h0004);
    vout_ov_i[0] <= 1'b1;
    tick(1);
    vout_ov_i[0] <= 1'b0;
    for (k = 0; k < 1999 && soft_start_o[0] !== 1'b1; k++)
      tick(1);
    `CHK("retry gap", 1'b1, k > 960 && k < 969)
    if (k == 1999)
      report_and_stop();
    tick(1);
    `CHK("pin", 1'b0, fault_pin_oe_o[0])
    // Neighbour pulls the bussed pin of channel 1
    wr_reg(REG_CMD, 16'h0001 << CMD_CLR);
    wr_reg(REG_PINRESP, 16'h0020);
    pull[1] <= 1'b1;
    tick(8);
    pull[1] <= 1'b0;
    `CHK("enables", 2'h1, chan_en_o)
    rd_chk(REG_STATUS, 16'h0020);
    // Pin disable, strap moves, then manufacturer reset
    wr_reg(REG_ST_ADDR, 16'h006a);
    wr_reg(REG_ST_VOUT1, 16'h0400);
    wr_reg(REG_GCFG, (16'h0001 << GCFG_PIN_DIS) | (16'h0001 << GCFG_SYNC_DIS));
    rd_chk(REG_PAD, 16'h0001 << PAD_SYNC_BIT);
    addr_low_strap_i <= 4'h9;
    strap_open_i[1] <= 1'b1;
    tick(12);
    `CHK("address", 7'h25, slave_addr_o)
    wr_reg(REG_CMD, 16'h0001 << CMD_MRST);
    tick(10);
    `CHK("address", 7'h69, slave_addr_o)
    `CHK("vout1", 16'h0400, vout1_o)
    rd_chk(REG_STATUS, 16'h0080);
    // Channel 0 pin as power-good, its input response set to ignore
    wr_reg(REG_PINRESP, 16'h0001);
    vout_uv_i[0] <= 1'b1;
    tick(3);
    `CHK("pg pin", 1'b1, fault_pin_oe_o[0])
    report_and_stop();
  end
endmodule
`default_nettype wire
